// File: bus_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model (
    // pins seen
    input wire logic clk_sys,
    input wire logic wide_bus_sel,
    input wire logic address_latch_strobe,
    input wire logic [15:0] muxed_word_lines_out,
    input wire logic [4:0] ctrl_pins_out,
    input wire logic ctrl_pins_oe_n,
    // pins driven
    output logic [15:0] muxed_word_lines_in
);
    logic [7:0] addr_reg = 8'h00;
    logic [15:0] last_reg = 16'h0000;
    logic [15:0] data;
    logic rd_act;
    // ========================================
    // external address latch
    always @(posedge clk_sys) begin
        if (address_latch_strobe) begin
            addr_reg <= muxed_word_lines_out[7:0];
        end
    end
    // ========================================
    // byte at a is a ^ 5a; wide bus serves both lanes
    assign rd_act = !ctrl_pins_oe_n && !ctrl_pins_out[3];
    assign data = wide_bus_sel ? {(addr_reg | 8'h01) ^ 8'h5a, (addr_reg & 8'hfe) ^ 8'h5a}
        : {addr_reg ^ 8'h5a, addr_reg ^ 8'h5a};
    always @(posedge clk_sys) begin
        if (rd_act) begin
            last_reg <= data;
        end
    end
    // released lines show the inverse of the last value
    assign muxed_word_lines_in = rd_act ? data : ~last_reg;
endmodule // bus_mem_model
`default_nettype wire

// File: bus_pin_ctrl.sv
// Summary of operation
// - narrow bus drives address bits 8 to 15 on mid address pins
// - narrow bus multiplexes low address byte and data byte on low lines
// - narrow bus moves a word as two bytes, low byte first
// - multiplexed lines float during hold and interrupt acknowledge
// - wide bus drives low sixteen address bits on multiplexed word lines
// - wide bus selects even bank by bit 0 low, odd with upper lane
// - floated low multiplexed lines keep their last driven level
// - halt acknowledge pulses strobe or queue bit 0 once, else low
// - control outputs high in reset, then float until first bus cycle
// - large-scale mode drives narrow low status pin constant high
// - wide odd word takes two cycles, upper lane first; even word one
// - hold grant floats address, data and three-state control outputs
`timescale 1ns/1ns
`default_nettype none
module bus_pin_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // device pins in
    input wire logic sys_reset,
    input wire logic size_mode_select,
    input wire logic wide_bus_sel,
    input wire logic bus_release_request,
    input wire logic [15:0] muxed_word_lines_in,
    // core cycle requests
    input wire logic cyc_start,
    input wire bus_pin_pkg::cyc_kind_t cyc_kind,
    input wire logic cyc_word,
    input wire logic [19:0] cyc_addr,
    input wire logic [15:0] cyc_wdata,
    output logic cyc_ready,
    output logic cyc_done,
    output logic [15:0] cyc_rdata,
    // address pins
    output logic [3:0] addr_top_out,
    output logic addr_top_oe_n,
    output logic [7:0] mid_address_pins_out,
    output logic mid_address_pins_oe_n,
    output logic [15:0] muxed_word_lines_out,
    output logic muxed_low_lines_oe_n,
    output logic muxed_high_lines_oe_n,
    // strobes, lane and status pins
    output logic address_latch_strobe,
    output logic queue_state_bit0,
    output logic upper_lane_enable_n,
    output logic upper_lane_enable_oe_n,
    output logic low_status_pin,
    output logic low_status_pin_oe_n,
    output logic [4:0] ctrl_pins_out,
    output logic ctrl_pins_oe_n,
    output logic hold_grant
);
    typedef bus_pin_pkg::bus_state_t st_t;
    // ========================================
    // pin synchronisers
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [15:0] din_meta_reg;
    logic [15:0] din_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 4'h1;
            sync_reg <= 4'h1;
        end else begin
            meta_reg <= {bus_release_request, wide_bus_sel, size_mode_select, sys_reset};
            sync_reg <= meta_reg;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            din_meta_reg <= 16'h0000;
            din_reg <= 16'h0000;
        end else begin
            din_meta_reg <= muxed_word_lines_in;
            din_reg <= din_meta_reg;
        end
    end
    logic rst_s;
    logic small_s;
    logic wide_s;
    logic hold_s;
    assign rst_s = sync_reg[bus_pin_pkg::SYNC_RESET];
    assign small_s = sync_reg[bus_pin_pkg::SYNC_SMALL];
    assign wide_s = sync_reg[bus_pin_pkg::SYNC_WIDE];
    assign hold_s = sync_reg[bus_pin_pkg::SYNC_HOLD];
    // ========================================
    // cycle state
    st_t state_reg;
    st_t state_next;
    bus_pin_pkg::cyc_kind_t kind_reg;
    logic word_reg;
    logic part_reg;
    logic started_reg;
    logic [19:0] cur_addr_reg;
    logic [15:0] wdata_reg;
    logic accept;
    logic two_part;
    logic [19:0] next_addr;
    assign next_addr = 20'(cur_addr_reg + 20'h00001);
    assign accept = (state_next == bus_pin_pkg::ST_T1)
        && (state_reg == bus_pin_pkg::ST_IDLE || state_reg == bus_pin_pkg::ST_HALT);
    assign two_part = word_reg && (!wide_s || cur_addr_reg[0]);
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bus_pin_pkg::ST_RESET: state_next = bus_pin_pkg::ST_IDLE;
            bus_pin_pkg::ST_IDLE, bus_pin_pkg::ST_HALT: begin
                if (hold_s) begin
                    state_next = bus_pin_pkg::ST_HOLD;
                end else if (cyc_start) begin
                    state_next = bus_pin_pkg::ST_T1;
                end
            end
            bus_pin_pkg::ST_T1: begin
                if (kind_reg == bus_pin_pkg::KIND_HALT) begin
                    state_next = bus_pin_pkg::ST_HALT;
                end else begin
                    state_next = bus_pin_pkg::ST_T2;
                end
            end
            bus_pin_pkg::ST_T2: state_next = bus_pin_pkg::ST_T3;
            bus_pin_pkg::ST_T3: state_next = bus_pin_pkg::ST_T4;
            bus_pin_pkg::ST_T4: begin
                if (two_part && !part_reg) begin
                    state_next = bus_pin_pkg::ST_T1;
                end else begin
                    state_next = bus_pin_pkg::ST_IDLE;
                end
            end
            bus_pin_pkg::ST_HOLD: begin
                if (!hold_s) begin
                    state_next = bus_pin_pkg::ST_IDLE;
                end
            end
            default: state_next = bus_pin_pkg::ST_IDLE;
        endcase
        if (rst_s) begin
            state_next = bus_pin_pkg::ST_RESET;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= bus_pin_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            kind_reg <= bus_pin_pkg::KIND_MEM_RD;
            word_reg <= 1'b0;
            part_reg <= 1'b0;
            cur_addr_reg <= 20'h00000;
            wdata_reg <= 16'h0000;
        end else if (accept) begin
            kind_reg <= cyc_kind;
            word_reg <= cyc_word;
            part_reg <= 1'b0;
            cur_addr_reg <= cyc_addr;
            wdata_reg <= cyc_wdata;
        end else if (state_reg == bus_pin_pkg::ST_T4 && state_next == bus_pin_pkg::ST_T1) begin
            part_reg <= 1'b1;
            cur_addr_reg <= next_addr;
        end
    end
    // ========================================
    // lane steering
    logic full_word;
    logic [7:0] part_byte;
    logic [15:0] wr_lanes;
    logic [7:0] rd_byte;
    logic ube_act;
    logic reading;
    logic data_phase;
    bus_pin_pkg::cyc_kind_t cur_kind;
    assign cur_kind = accept ? cyc_kind : kind_reg;
    assign full_word = wide_s && word_reg && !cur_addr_reg[0] && !part_reg;
    assign part_byte = part_reg ? wdata_reg[15:8] : wdata_reg[7:0];
    assign rd_byte = (wide_s && cur_addr_reg[0]) ? din_reg[15:8] : din_reg[7:0];
    assign ube_act = full_word || cur_addr_reg[0];
    assign reading = !bus_pin_pkg::is_write(cur_kind);
    always_comb begin
        wr_lanes = {8'h00, part_byte};
        if (full_word) begin
            wr_lanes = wdata_reg;
        end else if (wide_s && cur_addr_reg[0]) begin
            wr_lanes = {part_byte, 8'h00};
        end
    end
    assign data_phase = (state_next == bus_pin_pkg::ST_T2) || (state_next == bus_pin_pkg::ST_T3)
        || (state_next == bus_pin_pkg::ST_T4);
    logic floating;
    logic in_cycle;
    assign floating = (state_next == bus_pin_pkg::ST_HOLD) || (state_next == bus_pin_pkg::ST_RESET);
    assign in_cycle = (state_next == bus_pin_pkg::ST_T1) || data_phase;
    logic ctrl_drive;
    logic [2:0] bus_code;
    assign ctrl_drive = !floating && (started_reg || accept);
    assign bus_code = (state_next == bus_pin_pkg::ST_T1 || state_next == bus_pin_pkg::ST_T2)
        ? bus_pin_pkg::state_code(cur_kind) : bus_pin_pkg::BSC_PASSIVE;
    // ========================================
    // core answer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cyc_ready <= 1'b0;
            cyc_done <= 1'b0;
            cyc_rdata <= 16'h0000;
            started_reg <= 1'b0;
        end else begin
            cyc_ready <= (state_next == bus_pin_pkg::ST_IDLE || state_next == bus_pin_pkg::ST_HALT)
                && !rst_s && !hold_s;
            cyc_done <= (state_reg == bus_pin_pkg::ST_T4) && (state_next != bus_pin_pkg::ST_T1);
            if (state_reg == bus_pin_pkg::ST_T4 && reading) begin
                if (full_word) begin
                    cyc_rdata <= din_reg;
                end else if (part_reg) begin
                    cyc_rdata[15:8] <= rd_byte;
                end else begin
                    cyc_rdata <= {8'h00, rd_byte};
                end
            end
            if (rst_s) begin
                started_reg <= 1'b0;
            end else if (accept) begin
                started_reg <= 1'b1;
            end
        end
    end
    // ========================================
    // address and data pins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addr_top_out <= 4'h0;
            mid_address_pins_out <= 8'h00;
            muxed_word_lines_out <= 16'h0000;
            addr_top_oe_n <= 1'b1;
            mid_address_pins_oe_n <= 1'b1;
            muxed_low_lines_oe_n <= 1'b1;
            muxed_high_lines_oe_n <= 1'b1;
        end else begin
            addr_top_oe_n <= !in_cycle;
            mid_address_pins_oe_n <= !in_cycle || wide_s;
            muxed_low_lines_oe_n <= !in_cycle || (data_phase && reading);
            muxed_high_lines_oe_n <= !in_cycle || !wide_s || (data_phase && reading);
            if (state_next == bus_pin_pkg::ST_T1) begin
                addr_top_out <= accept ? cyc_addr[19:16] : next_addr[19:16];
                mid_address_pins_out <= accept ? cyc_addr[15:8] : next_addr[15:8];
                muxed_word_lines_out <= accept ? cyc_addr[15:0] : next_addr[15:0];
            end else if (state_next == bus_pin_pkg::ST_T2 && !reading) begin
                muxed_word_lines_out <= wr_lanes;
            end
        end
    end
    // ========================================
    // strobes, lane, status and control pins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            address_latch_strobe <= 1'b0;
            queue_state_bit0 <= 1'b0;
            upper_lane_enable_n <= 1'b1;
            upper_lane_enable_oe_n <= 1'b1;
            low_status_pin <= 1'b1;
            low_status_pin_oe_n <= 1'b1;
            ctrl_pins_out <= bus_pin_pkg::CTRL_RESET_VAL;
            ctrl_pins_oe_n <= 1'b1;
            hold_grant <= 1'b0;
        end else begin
            hold_grant <= state_next == bus_pin_pkg::ST_HOLD;
            address_latch_strobe <= small_s && (state_next == bus_pin_pkg::ST_T1);
            queue_state_bit0 <= !small_s && (state_next == bus_pin_pkg::ST_T1) && accept
                && (cyc_kind == bus_pin_pkg::KIND_HALT);
            upper_lane_enable_oe_n <= floating || !started_reg || !wide_s;
            if (state_next == bus_pin_pkg::ST_HALT) begin
                upper_lane_enable_n <= 1'b1;
            end else if (state_reg == bus_pin_pkg::ST_T1) begin
                upper_lane_enable_n <= !ube_act;
            end
            low_status_pin_oe_n <= floating || wide_s || (small_s && !started_reg);
            if (!small_s || state_next == bus_pin_pkg::ST_HALT) begin
                low_status_pin <= 1'b1;
            end else if (state_reg == bus_pin_pkg::ST_T1) begin
                low_status_pin <= bus_pin_pkg::state_code(kind_reg) != bus_pin_pkg::BSC_MEM_RD;
            end
            if (state_next == bus_pin_pkg::ST_RESET) begin
                ctrl_pins_out <= bus_pin_pkg::CTRL_RESET_VAL;
                ctrl_pins_oe_n <= 1'b0;
            end else begin
                ctrl_pins_oe_n <= !ctrl_drive;
            end
            if (ctrl_drive && small_s) begin
                ctrl_pins_out[bus_pin_pkg::CTRL_BUF_EN] <= !data_phase;
                ctrl_pins_out[bus_pin_pkg::CTRL_BUF_DIR] <= !reading;
                ctrl_pins_out[bus_pin_pkg::CTRL_IO_MEM] <= wide_s
                    ^ (cur_kind == bus_pin_pkg::KIND_IO_RD
                    || cur_kind == bus_pin_pkg::KIND_IO_WR);
                ctrl_pins_out[bus_pin_pkg::CTRL_WR] <= !(data_phase && !reading
                    && state_next != bus_pin_pkg::ST_T4);
            end else if (ctrl_drive) begin
                ctrl_pins_out[2:0] <= bus_code;
                ctrl_pins_out[bus_pin_pkg::CTRL_WR] <= 1'b1;
            end
            if (ctrl_drive) begin
                ctrl_pins_out[bus_pin_pkg::CTRL_RD] <= !(data_phase && reading
                    && state_next != bus_pin_pkg::ST_T4);
            end
        end
    end
    // ========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_first_part;
        state_reg == bus_pin_pkg::ST_T4 && two_part && !part_reg;
    endsequence
    sequence s_second_t1;
        state_reg == bus_pin_pkg::ST_T1 && part_reg;
    endsequence
    a_mid_addr_out: assert property (state_reg == bus_pin_pkg::ST_T1 && !wide_s && !rst_s
        |-> !mid_address_pins_oe_n && mid_address_pins_out == cur_addr_reg[15:8])
        else $error("mid address pins wrong in address phase");
    a_low_addr_mux: assert property (state_reg == bus_pin_pkg::ST_T1 && !rst_s
        |-> muxed_word_lines_out[7:0] == cur_addr_reg[7:0] && !muxed_low_lines_oe_n)
        else $error("low lines do not carry address");
    a_word_two_parts: assert property ((s_first_part and (!rst_s && !hold_s))
        |=> s_second_t1)
        else $error("second byte cycle missing");
    a_float_inta_hold: assert property (hold_grant || (kind_reg == bus_pin_pkg::KIND_INTA
        && state_reg == bus_pin_pkg::ST_T3) |-> muxed_low_lines_oe_n)
        else $error("multiplexed lines driven while they must float");
    a_wide_addr_out: assert property (state_reg == bus_pin_pkg::ST_T1 && wide_s && !rst_s
        |-> muxed_word_lines_out == cur_addr_reg[15:0] && !muxed_high_lines_oe_n)
        else $error("word lines do not carry address");
    a_lane_bank_sel: assert property (state_reg == bus_pin_pkg::ST_T2 && wide_s && !rst_s
        |-> upper_lane_enable_n == !ube_act)
        else $error("upper lane enable disagrees with bank bit");
    a_float_keep_level: assert property (muxed_low_lines_oe_n && $past(muxed_low_lines_oe_n)
        |-> $stable(muxed_word_lines_out))
        else $error("floated line level changed");
    a_halt_pulse_once: assert property ($rose(queue_state_bit0) |=> !queue_state_bit0 [*2])
        else $error("queue bit 0 pulse too long");
    a_reset_ctrl_high: assert property (state_next == bus_pin_pkg::ST_RESET
        |=> !ctrl_pins_oe_n && ctrl_pins_out == bus_pin_pkg::CTRL_RESET_VAL)
        else $error("control pins not high in reset");
    a_status_high: assert property (!small_s && !low_status_pin_oe_n |-> low_status_pin)
        else $error("low status pin not high in large mode");
    a_hold_floats: assert property (hold_grant |-> addr_top_oe_n && mid_address_pins_oe_n
        && muxed_low_lines_oe_n && ctrl_pins_oe_n && upper_lane_enable_oe_n)
        else $error("outputs driven during hold");
    a_grant_boundary: assert property ($rose(hold_grant) |-> $past(state_reg) == bus_pin_pkg::ST_IDLE
        || $past(state_reg) == bus_pin_pkg::ST_HALT)
        else $error("hold granted inside a transfer");
endmodule // bus_pin_ctrl
`default_nettype wire

// File: bus_pin_pkg.sv
`default_nettype none
package bus_pin_pkg;
    // ========================================
    // widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYNC_IN_W = 4;
    // ========================================
    // synchroniser bit positions
    localparam int SYNC_RESET = 0;
    localparam int SYNC_SMALL = 1;
    localparam int SYNC_WIDE = 2;
    localparam int SYNC_HOLD = 3;
    // ========================================
    // control pin group positions and reset value
    localparam int CTRL_W = 5;
    localparam int CTRL_BUF_EN = 0;
    localparam int CTRL_BUF_DIR = 1;
    localparam int CTRL_IO_MEM = 2;
    localparam int CTRL_RD = 3;
    localparam int CTRL_WR = 4;
    localparam logic [4:0] CTRL_RESET_VAL = 5'h1f;
    // ========================================
    // bus state codes for large-scale mode
    localparam logic [2:0] BSC_INTA = 3'h0;
    localparam logic [2:0] BSC_IO_RD = 3'h1;
    localparam logic [2:0] BSC_IO_WR = 3'h2;
    localparam logic [2:0] BSC_HALT = 3'h3;
    localparam logic [2:0] BSC_MEM_RD = 3'h5;
    localparam logic [2:0] BSC_MEM_WR = 3'h6;
    localparam logic [2:0] BSC_PASSIVE = 3'h7;
    // ========================================
    // states and cycle kinds
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_T1 = 3'h1, ST_T2 = 3'h3, ST_T3 = 3'h2,
        ST_T4 = 3'h6, ST_HALT = 3'h4, ST_HOLD = 3'h5, ST_RESET = 3'h7
    } bus_state_t;
    typedef enum logic [2:0] {
        KIND_MEM_RD = 3'h0, KIND_MEM_WR = 3'h1, KIND_IO_RD = 3'h2,
        KIND_IO_WR = 3'h3, KIND_INTA = 3'h4, KIND_HALT = 3'h5
    } cyc_kind_t;
    // ========================================
    // status code of a cycle kind
    function automatic logic [2:0] state_code(cyc_kind_t k);
        case (k)
            KIND_MEM_RD: state_code = BSC_MEM_RD;
            KIND_MEM_WR: state_code = BSC_MEM_WR;
            KIND_IO_RD: state_code = BSC_IO_RD;
            KIND_IO_WR: state_code = BSC_IO_WR;
            KIND_INTA: state_code = BSC_INTA;
            default: state_code = BSC_HALT;
        endcase
    endfunction
    function automatic logic is_write(cyc_kind_t k);
        is_write = (k == KIND_MEM_WR) || (k == KIND_IO_WR);
    endfunction
endpackage
`default_nettype wire

// File: cpu_bus_pin_state_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_pin_state_control_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic sys_reset = 1'b0;
    logic size_mode_select = 1'b1;
    logic wide_bus_sel = 1'b0;
    logic bus_release_request = 1'b0;
    logic cyc_start = 1'b0;
    bus_pin_pkg::cyc_kind_t cyc_kind = bus_pin_pkg::KIND_MEM_RD;
    logic cyc_word = 1'b0;
    logic [19:0] cyc_addr = 20'h00000;
    logic [15:0] cyc_wdata = 16'h0000;
    logic [15:0] muxed_word_lines_in, muxed_word_lines_out, cyc_rdata;
    logic [7:0] mid_address_pins_out;
    logic [4:0] ctrl_pins_out;
    logic [3:0] addr_top_out;
    logic cyc_ready, cyc_done, addr_top_oe_n, mid_address_pins_oe_n, muxed_low_lines_oe_n;
    logic muxed_high_lines_oe_n, address_latch_strobe, queue_state_bit0, upper_lane_enable_n;
    logic upper_lane_enable_oe_n, low_status_pin, low_status_pin_oe_n, ctrl_pins_oe_n, hold_grant;
    int err_total = 0;
    int total_checks = 0;
    int lat, late_drv, gseen, req_mid, p;
    logic [19:0] aq[$];
    logic ule_q[$];
    logic [15:0] wq[$];
    // ========================================
    // design and far side
    bus_pin_ctrl i_dut (.*);
    bus_mem_model i_mem (.*);
    always #5 clk_sys = ~clk_sys;
    // ========================================
    // helpers
    function automatic logic [7:0] f(logic [7:0] a);
        return a ^ 8'h5a;
    endfunction
    task automatic chk(string name, logic [19:0] got, logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic issue(bus_pin_pkg::cyc_kind_t k, logic w, logic [19:0] a, logic [15:0] d);
        int n;
        n = 0;
        while (cyc_ready !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        if (n >= 50) err_total++;
        cyc_kind = k;
        cyc_word = w;
        cyc_addr = a;
        cyc_wdata = d;
        cyc_start = 1'b1;
        tick();
        cyc_start = 1'b0;
    endtask
    task automatic run(bus_pin_pkg::cyc_kind_t k, logic w, logic [19:0] a, logic [15:0] d);
        logic wr_prev;
        logic stb_d;
        aq.delete();
        ule_q.delete();
        wq.delete();
        late_drv = 0;
        gseen = 0;
        wr_prev = 1'b1;
        stb_d = 1'b0;
        lat = 0;
        issue(k, w, a, d);
        if (req_mid) bus_release_request = 1'b1;
        do begin
            if (stb_d) ule_q.push_back(upper_lane_enable_n);
            stb_d = address_latch_strobe;
            if (address_latch_strobe) begin
                aq.push_back(wide_bus_sel ? {addr_top_out, muxed_word_lines_out}
                    : {addr_top_out, mid_address_pins_out, muxed_word_lines_out[7:0]});
            end else if (aq.size() > 0 && !muxed_low_lines_oe_n) late_drv = 1;
            if (!ctrl_pins_out[4] && wr_prev) wq.push_back(muxed_word_lines_out);
            wr_prev = ctrl_pins_out[4];
            if (hold_grant) gseen = 1;
            tick();
            lat++;
        end while (cyc_done !== 1'b1 && lat < 40);
        if (lat >= 40) err_total++;
    endtask
    // ========================================
    // straps change only under reset
    task automatic strap(logic s, logic w);
        arst_n = 1'b0;
        size_mode_select = s;
        wide_bus_sel = w;
        repeat (6) tick();
        arst_n = 1'b1;
        repeat (3) tick();
    endtask
    // ========================================
    // scenarios
    task t_reset;
        sys_reset = 1'b1;
        repeat (4) tick();
        chk("ctrl in reset", {ctrl_pins_oe_n, ctrl_pins_out}, 20'h0001f);
        chk("addr float", {addr_top_oe_n, muxed_low_lines_oe_n}, 20'h3);
        sys_reset = 1'b0;
        repeat (4) tick();
        chk("ctrl after reset", {ctrl_pins_oe_n, ctrl_pins_out}, 20'h0003f);
    endtask
    task t_narrow;
        run(bus_pin_pkg::KIND_MEM_RD, 1'b1, 20'h12345, 16'h0000);
        chk("narrow word latency", 20'(lat), 20'd8);
        chk("first address", aq[0], 20'h12345);
        chk("second address", aq[1], 20'h12346);
        chk("narrow rdata", cyc_rdata, {f(8'h46), f(8'h45)});
        chk("read lines float", 20'(late_drv), 20'd0);
        run(bus_pin_pkg::KIND_MEM_WR, 1'b1, 20'h0f0f0, 16'hbeef);
        chk("low byte first", wq[0][7:0], 20'hef);
        chk("high byte second", wq[1][7:0], 20'hbe);
        run(bus_pin_pkg::KIND_INTA, 1'b0, 20'h00000, 16'h0000);
        chk("inta lines float", 20'(late_drv), 20'd0);
    endtask
    task t_halt;
        issue(bus_pin_pkg::KIND_HALT, 1'b0, 20'h00000, 16'h0000);
        p = 0;
        repeat (12) begin
            p += size_mode_select ? address_latch_strobe : queue_state_bit0;
            tick();
        end
        chk("halt pulses", 20'(p), 20'd1);
    endtask
    task t_wide;
        run(bus_pin_pkg::KIND_MEM_RD, 1'b1, 20'h00a10, 16'h0000);
        chk("even word latency", 20'(lat), 20'd4);
        chk("wide address", aq[0], 20'h00a10);
        chk("even word lane", 20'(ule_q[0]), 20'h0);
        chk("even word rdata", cyc_rdata, {f(8'h11), f(8'h10)});
        run(bus_pin_pkg::KIND_MEM_RD, 1'b1, 20'h00a11, 16'h0000);
        chk("odd word latency", 20'(lat), 20'd8);
        chk("odd word lanes", {ule_q[0], ule_q[1]}, 20'h1);
        chk("odd word second", aq[1], 20'h00a12);
        chk("odd word rdata", cyc_rdata, {f(8'h12), f(8'h11)});
        for (int i = 0; i < 2; i++) begin
            run(bus_pin_pkg::KIND_MEM_RD, 1'b0, 20'h00a20 + 20'(i), 16'h0000);
            chk("byte lane", 20'(ule_q[0]), 20'(1 - i));
        end
    endtask
    task t_hold;
        req_mid = 1;
        run(bus_pin_pkg::KIND_MEM_RD, 1'b1, 20'h00a11, 16'h0000);
        req_mid = 0;
        chk("no grant mid transfer", 20'(gseen), 20'd0);
        repeat (6) tick();
        chk("grant at boundary", 20'(hold_grant), 20'd1);
        chk("float in hold", {addr_top_oe_n, muxed_low_lines_oe_n, muxed_high_lines_oe_n,
            upper_lane_enable_oe_n, ctrl_pins_oe_n}, 20'h1f);
        chk("refused in hold", 20'(cyc_ready), 20'd0);
        bus_release_request = 1'b0;
        repeat (5) tick();
        chk("grant released", 20'(hold_grant), 20'd0);
    endtask
    task t_large;
        chk("low status high", {low_status_pin_oe_n, low_status_pin}, 20'h1);
        t_halt();
        chk("status after halt", {low_status_pin_oe_n, low_status_pin}, 20'h1);
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        req_mid = 0;
        repeat (6) tick();
        arst_n = 1'b1;
        repeat (3) tick();
        t_reset();
        t_narrow();
        t_halt();
        strap(1'b1, 1'b1);
        t_wide();
        t_hold();
        strap(1'b0, 1'b0);
        t_large();
        conclude();
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule // cpu_bus_pin_state_control_tb
`default_nettype wire
